// ==== src/phy_ctl_pkg.sv ====
// constants, field layouts and carrier types for the transceiver control registers
//
// Summary of operation
// - control bit 11 picks 15 or 9-stage sequence
// - bit 10 latches pass, cleared by any control register write
// - bit 9 starts continuous self-test, zero stops
// - bit 8 drives LEDs unstretched
// - bit 7 shows both sides pause capable
// - bits 4:0 port address, reset all ones
// - ten loopback bit ORed with basic-mode loopback
// - bit 7 or MAC force stops link pulses
// - bit 6 or MAC force forces link good
// - bit 5 forces inverted receive polarity
// - bit 4 latches inversion, a read of this or the status register clears it
// - bit 3 disables automatic polarity correction
// - bit 1 heartbeat off; only half-duplex 10
// - registers decoded at I/O base plus offset
`default_nettype none

package phy_ctl_pkg;

	// register offsets from the I/O base
	localparam logic [15:0] OFF_PAGE = 16'h00CC;
	localparam logic [15:0] OFF_CTRL = 16'h00E4;
	localparam logic [15:0] OFF_TENB = 16'h00E8;
	localparam logic [15:0] OFF_DSP = 16'h00F4;
	localparam logic [15:0] OFF_SDET = 16'h00F8;
	localparam logic [15:0] OFF_TDAT = 16'h00FC;
	localparam logic [15:0] PAGE_TUNING = 16'h0001;

	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h003F;
	localparam logic [15:0] TENB_RESET = 16'h0004;
	localparam logic [15:0] TUNE_RESET = 16'h0000;
	localparam logic [4:0] ADDR_RESET = 5'h1F;

	// control register fields
	localparam int CTRL_LONG_SEQ = 11;
	localparam int CTRL_RESULT = 10;
	localparam int CTRL_RUN = 9;
	localparam int CTRL_BYPASS = 8;
	localparam int CTRL_PAUSE = 7;
	// reserved position that reads one, as the reset value shows
	localparam int CTRL_RSVD_ONE = 5;
	localparam int CTRL_ADDR_HI = 4;

	// ten-base register fields
	localparam int TENB_LOOP = 8;
	localparam int TENB_LP_OFF = 7;
	localparam int TENB_FORCE_LINK = 6;
	localparam int TENB_INV_FORCE = 5;
	localparam int TENB_POL = 4;
	localparam int TENB_SENSE_OFF = 3;
	localparam int TENB_RSVD = 2;
	localparam int TENB_SQE_OFF = 1;

	// sequence generator taps and lock length
	localparam int SEQ_LONG_A = 14;
	localparam int SEQ_LONG_B = 13;
	localparam int SEQ_SHORT_A = 8;
	localparam int SEQ_SHORT_B = 4;
	localparam logic [3:0] SEQ_LOCK = 4'hF;
	localparam logic [14:0] SEQ_SEED = 15'h0001;

	// LED stretch time
	localparam int STRETCH_MS = 50;
	localparam int CLK_KHZ = 50000;
	localparam int STRETCH_CYCLES = STRETCH_MS * CLK_KHZ;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [15:0] data;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] medium_dependent_control;
		logic [15:0] signal_processing_config;
		logic [15:0] signal_detect_config;
		logic [15:0] test_data_value;
	} tuning_t;

endpackage : phy_ctl_pkg

`default_nettype wire

// ==== src/selftest_seq.sv ====
// pseudo-random self-test generator and self-synchronising checker
`default_nettype none

module selftest_seq
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic long_seq,
	input wire logic clear,
	input wire logic rx_bit,
	output logic tx_bit_r,
	output logic pass_r
);
	import phy_ctl_pkg::*;

	logic [14:0] gen_r;
	logic [14:0] chk_r;
	logic [3:0] lock_r;
	logic fb;
	logic pred;
	logic err_r;
	logic armed_r;

	assign fb = long_seq ? (gen_r[SEQ_LONG_A] ^ gen_r[SEQ_LONG_B])
		: (gen_r[SEQ_SHORT_A] ^ gen_r[SEQ_SHORT_B]);
	assign pred = long_seq ? (chk_r[SEQ_LONG_A] ^ chk_r[SEQ_LONG_B])
		: (chk_r[SEQ_SHORT_A] ^ chk_r[SEQ_SHORT_B]);

	// ----------------------------------------
	// generator
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset || !run)
		begin
			gen_r <= SEQ_SEED;
			tx_bit_r <= 1'b0;
		end
		else
		begin
			gen_r <= {gen_r[13:0], fb};
			tx_bit_r <= fb;
		end
	end

	// ----------------------------------------
	// checker
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset || !run)
		begin
			chk_r <= 15'h0000;
			lock_r <= 4'h0;
			armed_r <= 1'b0;
		end
		else
		begin
			// first sample after start is the idle zero, not part of the sequence
			armed_r <= 1'b1;
			if (armed_r)
			begin
				chk_r <= {chk_r[13:0], rx_bit};
				if (lock_r != SEQ_LOCK)
					lock_r <= lock_r + 4'h1;
			end
		end
	end

	// result latches; any mismatch once the checker has locked holds it at fail until the next control register write
	always_ff @(posedge core_clk)
	begin
		if (reset || clear)
		begin
			pass_r <= 1'b0;
			err_r <= 1'b0;
		end
		else if (run && lock_r == SEQ_LOCK)
		begin
			if (rx_bit != pred || err_r)
			begin
				err_r <= 1'b1;
				pass_r <= 1'b0;
			end
			else
				pass_r <= 1'b1;
		end
	end

endmodule : selftest_seq

`default_nettype wire

// ==== src/phy_ctl_regs.sv ====
// transceiver control and 10BASE-T status/control registers with tuning bank
`default_nettype none

module phy_ctl_regs
#(
	parameter logic [15:0] IO_BASE = 16'h0000,
	parameter int NUM_LEDS = 3,
	parameter int LED_STRETCH_CYCLES = phy_ctl_pkg::STRETCH_CYCLES
)
(
	input wire logic core_clk,
	input wire logic reset,
	input wire phy_ctl_pkg::reg_req_t reg_req,
	output logic [15:0] rd_data_r,
	output logic rd_valid_r,
	input wire logic basic_mode_ctrl_loopback,
	input wire logic mac_ten_link_force_in,
	input wire logic ten_link_raw,
	input wire logic local_pause_adv,
	input wire logic partner_pause_adv,
	input wire logic inverted_wire_seen,
	input wire logic status_reg_read,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic [NUM_LEDS-1:0] led_raw,
	input wire logic selftest_rx,
	output logic [NUM_LEDS-1:0] led_out_r,
	output logic ten_loopback_r,
	output logic link_pulse_off_r,
	output logic ten_link_good_r,
	output logic inverted_wire_force_r,
	output logic wire_sense_off_r,
	output logic sqe_test_en_r,
	output logic polarity_flag_r,
	output logic [4:0] port_mgmt_address_r,
	output logic selftest_run_r,
	output logic long_sequence_select_r,
	output logic selftest_tx_r,
	output phy_ctl_pkg::tuning_t tuning_r
);
	import phy_ctl_pkg::*;

	localparam int STRETCH_W = $clog2(LED_STRETCH_CYCLES + 1);
	localparam logic [STRETCH_W-1:0] STRETCH_LOAD = STRETCH_W'(LED_STRETCH_CYCLES);

	// ----------------------------------------
	// stored fields
	// ----------------------------------------
	logic [15:0] page_selector_r;
	logic led_stretch_bypass_r;
	logic pause_match_flag_r;
	logic ten_loopback_ctl_r;
	logic link_pulse_off_ctl_r;
	logic force_link_ctl_r;
	logic wire_sense_off_ctl_r;
	logic inverted_force_ctl_r;
	logic rsvd_bit_r;
	logic sqe_test_off_r;
	logic selftest_result;
	logic selftest_clear;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic hit_page;
	logic hit_e4;
	logic hit_ctrl;
	logic hit_mdc;
	logic hit_tenb;
	logic hit_dsp;
	logic hit_sdet;
	logic hit_tdat;
	logic tuning_page;
	logic wr_ctrl;
	logic wr_tenb;
	logic rd_tenb;

	function automatic logic at_offset(input logic [15:0] addr, input logic [15:0] off);
		at_offset = (addr == 16'(IO_BASE + off));
	endfunction : at_offset

	assign tuning_page = (page_selector_r == PAGE_TUNING);
	assign hit_page = at_offset(reg_req.addr, OFF_PAGE);
	assign hit_e4 = at_offset(reg_req.addr, OFF_CTRL);
	assign hit_ctrl = hit_e4 && !tuning_page;
	assign hit_mdc = hit_e4 && tuning_page;
	assign hit_tenb = at_offset(reg_req.addr, OFF_TENB);
	assign hit_dsp = at_offset(reg_req.addr, OFF_DSP);
	assign hit_sdet = at_offset(reg_req.addr, OFF_SDET);
	assign hit_tdat = at_offset(reg_req.addr, OFF_TDAT);
	assign wr_ctrl = reg_req.wr && hit_ctrl;
	assign wr_tenb = reg_req.wr && hit_tenb;
	assign rd_tenb = reg_req.rd && hit_tenb;
	assign selftest_clear = wr_ctrl;

	// ----------------------------------------
	// page selector and tuning bank
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
			page_selector_r <= TUNE_RESET;
		else if (reg_req.wr && hit_page)
			page_selector_r <= reg_req.data;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			tuning_r.medium_dependent_control <= TUNE_RESET;
			tuning_r.signal_processing_config <= TUNE_RESET;
			tuning_r.signal_detect_config <= TUNE_RESET;
			tuning_r.test_data_value <= TUNE_RESET;
		end
		else if (reg_req.wr)
		begin
			if (hit_mdc)
				tuning_r.medium_dependent_control <= reg_req.data;
			if (hit_dsp)
				tuning_r.signal_processing_config <= reg_req.data;
			if (hit_sdet)
				tuning_r.signal_detect_config <= reg_req.data;
			if (hit_tdat)
				tuning_r.test_data_value <= reg_req.data;
		end
	end

	// ----------------------------------------
	// transceiver control register
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			long_sequence_select_r <= CTRL_RESET[CTRL_LONG_SEQ];
			selftest_run_r <= CTRL_RESET[CTRL_RUN];
			led_stretch_bypass_r <= CTRL_RESET[CTRL_BYPASS];
			port_mgmt_address_r <= ADDR_RESET;
		end
		else if (wr_ctrl)
		begin
			long_sequence_select_r <= reg_req.data[CTRL_LONG_SEQ];
			selftest_run_r <= reg_req.data[CTRL_RUN];
			led_stretch_bypass_r <= reg_req.data[CTRL_BYPASS];
			port_mgmt_address_r <= reg_req.data[CTRL_ADDR_HI:0];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			pause_match_flag_r <= 1'b0;
		else
			pause_match_flag_r <= local_pause_adv && partner_pause_adv;
	end

	// ----------------------------------------
	// self-test engine
	// ----------------------------------------
	selftest_seq u_selftest
	(
		.core_clk(core_clk),
		.reset(reset),
		.run(selftest_run_r),
		.long_seq(long_sequence_select_r),
		.clear(selftest_clear),
		.rx_bit(selftest_rx),
		.tx_bit_r(selftest_tx_r),
		.pass_r(selftest_result)
	);

	// ----------------------------------------
	// 10BASE-T status/control register
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ten_loopback_ctl_r <= TENB_RESET[TENB_LOOP];
			link_pulse_off_ctl_r <= TENB_RESET[TENB_LP_OFF];
			force_link_ctl_r <= TENB_RESET[TENB_FORCE_LINK];
			inverted_force_ctl_r <= TENB_RESET[TENB_INV_FORCE];
			wire_sense_off_ctl_r <= TENB_RESET[TENB_SENSE_OFF];
			rsvd_bit_r <= TENB_RESET[TENB_RSVD];
			sqe_test_off_r <= TENB_RESET[TENB_SQE_OFF];
		end
		else if (wr_tenb)
		begin
			ten_loopback_ctl_r <= reg_req.data[TENB_LOOP];
			link_pulse_off_ctl_r <= reg_req.data[TENB_LP_OFF];
			force_link_ctl_r <= reg_req.data[TENB_FORCE_LINK];
			inverted_force_ctl_r <= reg_req.data[TENB_INV_FORCE];
			wire_sense_off_ctl_r <= reg_req.data[TENB_SENSE_OFF];
			rsvd_bit_r <= reg_req.data[TENB_RSVD];
			sqe_test_off_r <= reg_req.data[TENB_SQE_OFF];
		end
	end

	// inversion flag: a new detection in the clearing cycle keeps it set
	always_ff @(posedge core_clk)
	begin
		if (reset)
			polarity_flag_r <= 1'b0;
		else if (inverted_wire_seen)
			polarity_flag_r <= 1'b1;
		else if (rd_tenb || status_reg_read)
			polarity_flag_r <= 1'b0;
	end

	// ----------------------------------------
	// line-side controls
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ten_loopback_r <= 1'b0;
			link_pulse_off_r <= 1'b0;
			ten_link_good_r <= 1'b0;
			inverted_wire_force_r <= 1'b0;
			wire_sense_off_r <= 1'b0;
			sqe_test_en_r <= 1'b0;
		end
		else
		begin
			ten_loopback_r <= ten_loopback_ctl_r || basic_mode_ctrl_loopback;
			link_pulse_off_r <= link_pulse_off_ctl_r || mac_ten_link_force_in;
			ten_link_good_r <= force_link_ctl_r || mac_ten_link_force_in
				|| ten_link_raw;
			inverted_wire_force_r <= inverted_force_ctl_r;
			wire_sense_off_r <= wire_sense_off_ctl_r;
			sqe_test_en_r <= !sqe_test_off_r && !speed_100 && !full_duplex;
		end
	end

	// ----------------------------------------
	// LED pulse stretching
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LEDS; gi++)
		begin : g_led
			logic [STRETCH_W-1:0] hold_r;

			always_ff @(posedge core_clk)
			begin
				if (reset)
					hold_r <= '0;
				else if (led_raw[gi])
					hold_r <= STRETCH_LOAD;
				else if (hold_r != '0)
					hold_r <= hold_r - STRETCH_W'(1);
			end

			always_ff @(posedge core_clk)
			begin
				if (reset)
					led_out_r[gi] <= 1'b0;
				else if (led_stretch_bypass_r)
					led_out_r[gi] <= led_raw[gi];
				else
					led_out_r[gi] <= led_raw[gi] || (hold_r != '0);
			end
		end
	endgenerate

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [15:0] ctrl_view;
	logic [15:0] tenb_view;
	logic [15:0] rd_mux;

	always_comb
	begin
		ctrl_view = 16'h0000;
		ctrl_view[CTRL_LONG_SEQ] = long_sequence_select_r;
		ctrl_view[CTRL_RESULT] = selftest_result;
		ctrl_view[CTRL_RUN] = selftest_run_r;
		ctrl_view[CTRL_BYPASS] = led_stretch_bypass_r;
		ctrl_view[CTRL_PAUSE] = pause_match_flag_r;
		ctrl_view[CTRL_RSVD_ONE] = CTRL_RESET[CTRL_RSVD_ONE];
		ctrl_view[CTRL_ADDR_HI:0] = port_mgmt_address_r;
	end

	always_comb
	begin
		tenb_view = 16'h0000;
		tenb_view[TENB_LOOP] = ten_loopback_ctl_r;
		tenb_view[TENB_LP_OFF] = link_pulse_off_ctl_r;
		tenb_view[TENB_FORCE_LINK] = force_link_ctl_r;
		tenb_view[TENB_INV_FORCE] = inverted_force_ctl_r;
		tenb_view[TENB_POL] = polarity_flag_r;
		tenb_view[TENB_SENSE_OFF] = wire_sense_off_ctl_r;
		tenb_view[TENB_RSVD] = rsvd_bit_r;
		tenb_view[TENB_SQE_OFF] = sqe_test_off_r;
	end

	// unmapped offsets answer zero
	always_comb
	begin
		rd_mux = 16'h0000;
		if (hit_page)
			rd_mux = page_selector_r;
		else if (hit_ctrl)
			rd_mux = ctrl_view;
		else if (hit_mdc)
			rd_mux = tuning_r.medium_dependent_control;
		else if (hit_tenb)
			rd_mux = tenb_view;
		else if (hit_dsp)
			rd_mux = tuning_r.signal_processing_config;
		else if (hit_sdet)
			rd_mux = tuning_r.signal_detect_config;
		else if (hit_tdat)
			rd_mux = tuning_r.test_data_value;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			rd_data_r <= 16'h0000;
			rd_valid_r <= 1'b0;
		end
		else
		begin
			rd_valid_r <= reg_req.rd;
			if (reg_req.rd)
				rd_data_r <= rd_mux;
		end
	end

endmodule : phy_ctl_regs

`default_nettype wire

// ==== testbench/phy_ctl_sva.sv ====
// assertion checker bound to the transceiver control registers
`default_nettype none
module phy_ctl_sva
(
	input wire logic core_clk,
	input wire logic reset,
	input wire phy_ctl_pkg::reg_req_t reg_req,
	input wire logic [15:0] rd_data_r,
	input wire logic rd_valid_r,
	input wire logic basic_mode_ctrl_loopback,
	input wire logic mac_ten_link_force_in,
	input wire logic inverted_wire_seen,
	input wire logic status_reg_read,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic ten_loopback_r,
	input wire logic link_pulse_off_r,
	input wire logic ten_link_good_r,
	input wire logic sqe_test_en_r,
	input wire logic polarity_flag_r,
	input wire logic [4:0] port_mgmt_address_r
);
	import phy_ctl_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_read_answer: assert property (reg_req.rd |=> rd_valid_r)
		else $error("read not answered");
	chk_valid_cause: assert property (rd_valid_r |-> $past(reg_req.rd))
		else $error("read valid without read");
	chk_hole_zero: assert property ((reg_req.rd && reg_req.addr == 16'h0010)
		|=> rd_data_r == 16'h0000) else $error("unmapped read not zero");
	chk_loop_or: assert property (basic_mode_ctrl_loopback |=> ten_loopback_r)
		else $error("loopback not ored");
	chk_force_pulse: assert property (mac_ten_link_force_in |=> link_pulse_off_r)
		else $error("link pulses not stopped");
	chk_force_link: assert property (mac_ten_link_force_in [*2] |-> ten_link_good_r)
		else $error("link not forced good");
	chk_sqe_gate: assert property ((speed_100 || full_duplex) |=> !sqe_test_en_r)
		else $error("heartbeat on outside half ten");
	chk_pol_set: assert property ($rose(inverted_wire_seen) |=> polarity_flag_r)
		else $error("polarity not latched");
	chk_pol_clear: assert property ((status_reg_read && !inverted_wire_seen)
		|=> !polarity_flag_r) else $error("polarity not cleared");
	chk_addr_hold: assert property (!(reg_req.wr && reg_req.addr == OFF_CTRL)
		|=> $stable(port_mgmt_address_r)) else $error("address moved without write");
	// ----------------------------------------
	// coverage
	// ----------------------------------------
	cover property (reg_req.rd && reg_req.addr == OFF_TENB);
	cover property (polarity_flag_r ##1 !polarity_flag_r);
	cover property (reg_req.wr && reg_req.addr == OFF_PAGE);
endmodule : phy_ctl_sva

bind phy_ctl_regs phy_ctl_sva u_phy_ctl_sva (.core_clk(core_clk), .reset(reset),
	.reg_req(reg_req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
	.basic_mode_ctrl_loopback(basic_mode_ctrl_loopback), .mac_ten_link_force_in(mac_ten_link_force_in),
	.inverted_wire_seen(inverted_wire_seen), .status_reg_read(status_reg_read),
	.speed_100(speed_100), .full_duplex(full_duplex), .ten_loopback_r(ten_loopback_r),
	.link_pulse_off_r(link_pulse_off_r), .ten_link_good_r(ten_link_good_r),
	.sqe_test_en_r(sqe_test_en_r), .polarity_flag_r(polarity_flag_r),
	.port_mgmt_address_r(port_mgmt_address_r));
`default_nettype wire

// ==== testbench/phy_control_and_tenbase_regs_bench.sv ====
// self-checking bench for the transceiver control registers
`default_nettype none
module phy_control_and_tenbase_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import phy_ctl_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	reg_req_t reg_req = '0;
	logic basic_mode_ctrl_loopback = 0, mac_ten_link_force_in = 0, ten_link_raw = 0, loop_ok = 0;
	logic local_pause_adv = 0, partner_pause_adv = 0, inverted_wire_seen = 0;
	logic status_reg_read = 0, speed_100 = 0, full_duplex = 0;
	logic [2:0] led_raw = 3'h0;
	logic [2:0] led_out_r;
	logic [15:0] rd_data_r;
	logic [4:0] port_mgmt_address_r;
	logic rd_valid_r, ten_loopback_r, link_pulse_off_r, ten_link_good_r, selftest_tx_r;
	logic inverted_wire_force_r, wire_sense_off_r, sqe_test_en_r, polarity_flag_r;
	logic selftest_run_r, long_sequence_select_r;
	tuning_t tuning_r;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	wire logic selftest_rx = loop_ok ? selftest_tx_r : ~selftest_tx_r;
	wire logic [5:0] ten_outs = {ten_loopback_r, link_pulse_off_r, ten_link_good_r,
		inverted_wire_force_r, wire_sense_off_r, sqe_test_en_r};

	phy_ctl_regs #(.LED_STRETCH_CYCLES(8)) u_phy_ctl_regs (.core_clk, .reset, .reg_req,
		.rd_data_r, .rd_valid_r, .basic_mode_ctrl_loopback, .mac_ten_link_force_in, .ten_link_raw,
		.local_pause_adv, .partner_pause_adv, .inverted_wire_seen, .status_reg_read,
		.speed_100, .full_duplex, .led_raw, .selftest_rx, .led_out_r, .ten_loopback_r,
		.link_pulse_off_r, .ten_link_good_r, .inverted_wire_force_r, .wire_sense_off_r,
		.sqe_test_en_r, .polarity_flag_r, .port_mgmt_address_r, .selftest_run_r,
		.long_sequence_select_r, .selftest_tx_r, .tuning_r);

	// ----------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------
	initial
	begin
		forever #10 core_clk = ~core_clk;
	end

	task automatic stop_test;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			errors++;
			stop_test();
		end
	end

	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask : tick

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		tick();
		reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
		tick();
		reg_req.wr = 1'b0;
	endtask : wr

	task automatic rc(input string n, input logic [15:0] a, input logic [15:0] e,
		input logic [15:0] m = 16'hFFFF);
		tick();
		reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, data: 16'h0000};
		tick();
		reg_req.rd = 1'b0;
		chk("rd_valid", rd_valid_r, 16'h0001);
		chk(n, rd_data_r & m, e);
	endtask : rc

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rc("page", OFF_PAGE, 16'h0000);
		rc("ctrl", OFF_CTRL, 16'h003F);
		rc("tenb", OFF_TENB, 16'h0004);
		chk("addr", port_mgmt_address_r, 16'h001F);
	endtask : t_reset

	task automatic t_ctrl;
		wr(OFF_CTRL, 16'hFFFF);
		rc("ctrl_all", OFF_CTRL, 16'h0B1F, 16'hFFDF);
		chk("ctrl_on", {long_sequence_select_r, selftest_run_r, port_mgmt_address_r},
			16'h007F);
		wr(OFF_CTRL, 16'h0000);
		chk("ctrl_off", {long_sequence_select_r, selftest_run_r, port_mgmt_address_r},
			16'h0000);
	endtask : t_ctrl

	task automatic t_selftest;
		loop_ok = 1'b1;
		wr(OFF_CTRL, 16'h0A00);
		repeat (40) tick();
		rc("long_pass", OFF_CTRL, 16'h0E00, 16'hFFDF);
		wr(OFF_CTRL, 16'h0000);
		wr(OFF_CTRL, 16'h0200);
		rc("cleared", OFF_CTRL, 16'h0200, 16'hFFDF);
		repeat (50000) tick();
		rc("short_pass", OFF_CTRL, 16'h0600, 16'hFFDF);
		loop_ok = 1'b0;
		repeat (3) tick();
		loop_ok = 1'b1;
		repeat (40) tick();
		rc("fail_holds", OFF_CTRL, 16'h0200, 16'hFFDF);
		wr(OFF_CTRL, 16'h0000);
		rc("stopped", OFF_CTRL, 16'h0000, 16'hFFDF);
	endtask : t_selftest

	task automatic t_pause;
		local_pause_adv = 1'b1;
		partner_pause_adv = 1'b1;
		tick();
		rc("pause_on", OFF_CTRL, 16'h0080, 16'h0080);
		partner_pause_adv = 1'b0;
		tick();
		rc("pause_off", OFF_CTRL, 16'h0000, 16'h0080);
	endtask : t_pause

	task automatic t_ten;
		wr(OFF_TENB, 16'hFFFF);
		rc("tenb_all", OFF_TENB, 16'h01EE);
		chk("tenb_on", ten_outs, 16'h003E);
		wr(OFF_TENB, 16'h0006);
		tick();
		chk("sqe_off", ten_outs, 16'h0000);
		wr(OFF_TENB, 16'h0004);
		basic_mode_ctrl_loopback = 1'b1;
		mac_ten_link_force_in = 1'b1;
		repeat (2) tick();
		chk("mac_force", ten_outs, 16'h0039);
		basic_mode_ctrl_loopback = 1'b0;
		mac_ten_link_force_in = 1'b0;
		ten_link_raw = 1'b1;
		full_duplex = 1'b1;
		repeat (2) tick();
		chk("full_dup", ten_outs, 16'h0008);
		full_duplex = 1'b0;
		speed_100 = 1'b1;
		repeat (2) tick();
		chk("fast", ten_outs, 16'h0008);
		speed_100 = 1'b0;
		ten_link_raw = 1'b0;
	endtask : t_ten

	task automatic t_polarity;
		inverted_wire_seen = 1'b1;
		tick();
		inverted_wire_seen = 1'b0;
		tick();
		chk("pol_flag", polarity_flag_r, 16'h0001);
		rc("pol_set", OFF_TENB, 16'h0014);
		rc("pol_clr", OFF_TENB, 16'h0004);
		inverted_wire_seen = 1'b1;
		tick();
		inverted_wire_seen = 1'b0;
		status_reg_read = 1'b1;
		tick();
		status_reg_read = 1'b0;
		tick();
		chk("pol_sts", polarity_flag_r, 16'h0000);
	endtask : t_polarity

	task automatic t_led;
		wr(OFF_CTRL, 16'h0100);
		led_raw = 3'h5;
		repeat (2) tick();
		chk("led_byp", led_out_r, 16'h0005);
		led_raw = 3'h0;
		repeat (2) tick();
		chk("led_byp0", led_out_r, 16'h0000);
		wr(OFF_CTRL, 16'h0000);
		led_raw = 3'h2;
		tick();
		led_raw = 3'h0;
		repeat (4) tick();
		chk("led_hold", led_out_r, 16'h0002);
		repeat (10) tick();
		chk("led_end", led_out_r, 16'h0000);
	endtask : t_led

	task automatic t_tune;
		wr(OFF_PAGE, PAGE_TUNING);
		wr(OFF_CTRL, 16'h189C);
		wr(OFF_TDAT, 16'h0000);
		wr(OFF_DSP, 16'h5040);
		wr(OFF_SDET, 16'h008C);
		chk("t_mdc", tuning_r.medium_dependent_control, 16'h189C);
		chk("t_dsp", tuning_r.signal_processing_config, 16'h5040);
		chk("t_sdet", tuning_r.signal_detect_config, 16'h008C);
		rc("mdc_rd", OFF_CTRL, 16'h189C);
		rc("tdat_rd", OFF_TDAT, 16'h0000);
		wr(OFF_PAGE, 16'h0000);
		rc("ctrl_back", OFF_CTRL, 16'h0000, 16'hFFDF);
		wr(16'h0010, 16'hFFFF);
		rc("hole", 16'h0010, 16'h0000);
	endtask : t_tune

	initial
	begin
		repeat (20) tick();
		reset = 1'b0;
		t_reset();
		t_ctrl();
		t_selftest();
		t_pause();
		t_ten();
		t_polarity();
		t_led();
		t_tune();
		reset = 1'b1;
		repeat (2) tick();
		reset = 1'b0;
		t_reset();
		stop_test();
	end
endmodule : phy_control_and_tenbase_regs_bench
`default_nettype wire
